// file: dac_regs_pkg.sv
package dac_regs_pkg;
  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'h55;
  localparam logic [7:0] CFG_IDX = 8'h57;
  localparam logic [7:0] CODE_IDX = 8'h01;
  localparam logic [7:0] GAIN_IDX = 8'h58;
  localparam logic [7:0] ZERO_IDX = 8'h59;
  localparam logic [7:0] STAT_IDX = 8'h5a;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_WR_MASK = 16'h07bf;
  localparam int CFG_IRNG_LSB = 9;
  localparam int CFG_DUAL = 8;
  localparam int CFG_APD = 7;
  localparam int CFG_CAL = 5;
  localparam int CFG_MODEM = 4;
  localparam int CFG_FCHK = 3;
  localparam int CFG_WATCHDOG_ENABLE = 2;
  localparam int CFG_WDPD_LSB = 0;

  // ---------------------------------------------------------------
  // Control fields and range codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_WR_MASK = 16'hfff7;
  localparam int CTRL_CLEAR_VALUE_SELECT = 15;
  localparam int CTRL_OUTEN = 12;
  localparam int CTRL_RANGE_LSB = 0;
  localparam logic [2:0] RANGE_LOOP_4_20 = 3'h5;
  localparam logic [2:0] RANGE_BIP_5 = 3'h2;
  localparam logic [2:0] RANGE_BIP_10 = 3'h3;

  // ---------------------------------------------------------------
  // Reset values and code constants
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hffff;
  localparam logic [15:0] LOW_NIBBLE_CLR = 16'hfff0;
  localparam logic [16:0] GAIN_UNITY = 17'h10000;
endpackage : dac_regs_pkg

// file: dac_trim_calc.sv
`timescale 1ns/1ps
module dac_trim_calc #(
  parameter int RES_BITS = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cal_en,
  input wire logic [15:0] code,
  input wire logic [15:0] gain,
  input wire logic [15:0] zero,
  output logic [15:0] code_out
);
  import dac_regs_pkg::*;

  typedef struct packed {
    logic [15:0] code;
  } trim_st_t;

  trim_st_t s;
  trim_st_t next_s;
  logic [32:0] prod;
  logic signed [18:0] sum;

  // Only the two documented resolutions have a datapath
  if (RES_BITS != 16 && RES_BITS != 12) begin : g_bad_res
    $error("RES_BITS must be 12 or 16");
  end

  // ---------------------------------------------------------------
  // Gain scales by (1 + g/65536), zero adds a signed offset
  // ---------------------------------------------------------------
  // Saturate instead of wrapping so a large trim cannot fold the output
  always_comb begin
    next_s = s;
    prod = 33'(code) * 33'(GAIN_UNITY + 17'(gain));
    // Spare top bit: full scale plus a positive offset must not wrap
    sum = $signed({2'b00, prod[32:16]}) + 19'($signed(zero));
    if (!cal_en) begin
      next_s.code = code;
    end else if (sum < 0) begin
      next_s.code = CODE_ZERO; // [R9]
    end else if (sum > $signed({3'b000, CODE_FULL})) begin
      next_s.code = CODE_FULL; // [R9]
    end else begin
      next_s.code = sum[15:0]; // [R9]
    end
    if (RES_BITS == 12) begin
      next_s.code = next_s.code & LOW_NIBBLE_CLR; // [R16]
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign code_out = s.code;

  AST_CAL_BYPASS: assert property (@(posedge core_clk) // [R9]
    disable iff (rst) !cal_en |=> code_out == $past(code))
    else $error("calibration off but code altered");
endmodule : dac_trim_calc

// file: dac_config_regs.sv
`timescale 1ns/1ps
// Function
// R1 - Configuration register lives at index 57h
// R2 - Host writes zeros to top five bits
// R3 - Secondary current range used only in dual mode
// R4 - Secondary range decodes like low range bits
// R5 - Secondary range write keeps output code
// R6 - Dual enable: both outputs, one code
// R7 - Power-down bit grounds sense node via resistor
// R8 - Host writes zero to configuration bit six
// R9 - Calibration enable applies gain and zero trim
// R10 - Modem input connected only in 4-20 mA
// R11 - Frame check enable turns frame checking on
// R12 - Watchdog enable starts the watchdog timer
// R13 - Low two bits select watchdog period
// R14 - Output code sixteen-bit unsigned, resets zero
// R15 - Gain trim sixteen-bit unsigned, resets zero
// R16 - Twelve-bit variant keeps bits fifteen to four
// R17 - Twelve-bit variant low nibble ignored, reads zero
// R18 - Zero trim two's complement, resets zero
// R19 - Range change clears code by clear select
// R20 - Control register lives at index 55h
// R21 - Configuration reads back fields, reserved zero
module dac_config_regs #(
  parameter int RES_BITS = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dac_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] calibrated_code,
  output logic voltage_output_on,
  output logic current_output_on,
  output logic [1:0] current_range_active,
  output logic sense_ground_en,
  output logic modem_connect_en,
  output logic frame_check_enable,
  output logic watchdog_enable,
  output logic [1:0] watchdog_period_select
);
  import dac_regs_pkg::*;

  // Every check below runs on the core clock; all but AST_RESET_ZERO rest in reset
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] cfg;
    logic [15:0] code;
    logic [15:0] gain;
    logic [15:0] zero;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic volt_on;
    logic cur_on;
    logic [1:0] cur_rng;
    logic sense_gnd;
    logic modem_on;
  } regs_st_t;

  regs_st_t s;
  regs_st_t next_s;
  logic access;
  logic wr_take;
  logic hit;
  logic [7:0] idx;
  logic [15:0] wdata;
  logic [15:0] cal_code;

  // Only the two documented resolutions have a datapath
  if (RES_BITS != 16 && RES_BITS != 12) begin : g_bad_res
    $error("RES_BITS must be 12 or 16");
  end

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Word-aligned address at one of the six register indices, else unmapped
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    addr_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0) &&
      (i == CTRL_IDX || i == CFG_IDX || i == CODE_IDX ||
       i == GAIN_IDX || i == ZERO_IDX || i == STAT_IDX);
  endfunction : addr_ok

  // Clear value for a range: bipolar zero volts is midscale
  function automatic logic [15:0] clear_code(input logic [15:0] c);
    logic [2:0] r;
    logic bip;
    r = c[CTRL_RANGE_LSB +: 3];
    bip = (r == RANGE_BIP_5) || (r == RANGE_BIP_10);
    if (r[2]) begin
      clear_code = CODE_ZERO; // [R19]
    end else if (c[CTRL_CLEAR_VALUE_SELECT]) begin
      clear_code = bip ? CODE_ZERO : CODE_MID; // [R19]
    end else begin
      clear_code = bip ? CODE_MID : CODE_ZERO; // [R19]
    end
  endfunction : clear_code

  // Twelve-bit parts drop the low nibble of data words
  function automatic logic [15:0] res_mask(input logic [15:0] d);
    res_mask = (RES_BITS == 12) ? (d & LOW_NIBBLE_CLR) : d;
  endfunction : res_mask

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // One wait state keeps every bus output straight from a flop
  assign access = psel && penable;
  assign wr_take = access && s.ready && pwrite;
  assign idx = paddr[9:2];
  assign hit = addr_ok(paddr);
  assign wdata = pwdata[15:0];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ready = access && !s.ready;
    next_s.slverr = access && !s.ready && !hit;
    next_s.rdata = '0;
    if (access && !s.ready && !pwrite && hit) begin
      unique case (idx)
        CTRL_IDX: next_s.rdata = {16'h0000, s.ctrl}; // [R20]
        CFG_IDX: next_s.rdata = {16'h0000, s.cfg}; // [R21]
        CODE_IDX: next_s.rdata = {16'h0000, s.code}; // [R17]
        GAIN_IDX: next_s.rdata = {16'h0000, s.gain}; // [R17]
        ZERO_IDX: next_s.rdata = {16'h0000, s.zero}; // [R17]
        default: next_s.rdata = {16'h0000, 10'h000, s.volt_on,
          s.cur_on, s.cur_rng, s.sense_gnd, s.modem_on};
      endcase
    end
    // Writes land on the edge where the master sees pready
    if (wr_take && hit) begin
      unique case (idx)
        CTRL_IDX: begin
          next_s.ctrl = wdata & CTRL_WR_MASK; // [R20]
          if (next_s.ctrl[CTRL_RANGE_LSB +: 3] !=
              s.ctrl[CTRL_RANGE_LSB +: 3]) begin
            next_s.code = res_mask(clear_code(next_s.ctrl)); // [R19]
          end
        end
        // Reserved bits are dropped so a careless host cannot set them
        CFG_IDX: next_s.cfg = wdata & CFG_WR_MASK; // [R1] [R5] [R21]
        CODE_IDX: next_s.code = res_mask(wdata); // [R14] [R16]
        GAIN_IDX: next_s.gain = res_mask(wdata); // [R15] [R16]
        ZERO_IDX: next_s.zero = res_mask(wdata); // [R18] [R17]
        default: next_s.code = s.code;
      endcase
    end
    // Output steering follows the registers as they will stand
    next_s.cur_rng = next_s.cfg[CFG_DUAL] ?
      next_s.cfg[CFG_IRNG_LSB +: 2] :
      next_s.ctrl[CTRL_RANGE_LSB +: 2]; // [R3] [R4]
    next_s.volt_on = next_s.ctrl[CTRL_OUTEN] &&
      (next_s.cfg[CFG_DUAL] || !next_s.ctrl[CTRL_RANGE_LSB + 2]); // [R6]
    next_s.cur_on = next_s.ctrl[CTRL_OUTEN] &&
      (next_s.cfg[CFG_DUAL] || next_s.ctrl[CTRL_RANGE_LSB + 2]); // [R6]
    next_s.sense_gnd = next_s.cfg[CFG_APD]; // [R7]
    // In dual mode the loop range comes from the secondary field
    next_s.modem_on = next_s.cfg[CFG_MODEM] &&
      ({1'b1, next_s.cur_rng} == RANGE_LOOP_4_20) &&
      (next_s.cfg[CFG_DUAL] || next_s.ctrl[CTRL_RANGE_LSB + 2]); // [R10]
  end

  // State register, one process for the whole bank
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0; // [R14] [R15] [R18]
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Calibration datapath
  // ---------------------------------------------------------------
  // Both outputs share the single code through one trim path
  dac_trim_calc #(
    .RES_BITS(RES_BITS)
  ) u_trim (
    .core_clk(core_clk),
    .rst(rst),
    .cal_en(s.cfg[CFG_CAL]),
    .code(s.code),
    .gain(s.gain),
    .zero(s.zero),
    .code_out(cal_code)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign calibrated_code = cal_code; // [R9]
  assign voltage_output_on = s.volt_on;
  assign current_output_on = s.cur_on;
  assign current_range_active = s.cur_rng;
  assign sense_ground_en = s.sense_gnd;
  assign modem_connect_en = s.modem_on;
  assign frame_check_enable = s.cfg[CFG_FCHK]; // [R11]
  assign watchdog_enable = s.cfg[CFG_WATCHDOG_ENABLE]; // [R12]
  assign watchdog_period_select = s.cfg[CFG_WDPD_LSB +: 2]; // [R13]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_write(logic [7:0] i);
    psel && penable && pwrite && pready && paddr == ADDR_W'({i, 2'b00});
  endsequence

  sequence s_wait_answer;
    psel && penable && !pready ##1 pready;
  endsequence

  AST_CFG_WRITE: assert property (s_write(CFG_IDX) |=> // [R1]
    s.cfg == ($past(pwdata[15:0]) & CFG_WR_MASK))
    else $error("configuration write not stored");
  AST_CTRL_WRITE: assert property (s_write(CTRL_IDX) |=> // [R20]
    s.ctrl == ($past(pwdata[15:0]) & CTRL_WR_MASK))
    else $error("control write not stored");
  AST_CODE_KEPT: assert property (s_write(CFG_IDX) |=> // [R5]
    $stable(s.code))
    else $error("configuration write moved output code");
  AST_RANGE_CLEAR: assert property (s_write(CTRL_IDX) ##1 // [R19]
    $changed(s.ctrl[2:0]) |-> s.code == res_mask(clear_code(s.ctrl)))
    else $error("range change did not clear code");
  AST_SEC_RANGE: assert property (current_range_active == // [R3] [R4]
    (s.cfg[CFG_DUAL] ? s.cfg[CFG_IRNG_LSB +: 2] :
    s.ctrl[CTRL_RANGE_LSB +: 2]))
    else $error("effective current range wrong");
  AST_DUAL_BOTH: assert property (s.cfg[CFG_DUAL] && // [R6]
    s.ctrl[CTRL_OUTEN] |-> voltage_output_on && current_output_on)
    else $error("dual mode without both outputs");
  AST_APD_FOLLOW: assert property (s_write(CFG_IDX) |=> // [R7]
    sense_ground_en == $past(pwdata[CFG_APD]))
    else $error("sense grounding does not follow write");
  AST_MODEM_GATE: assert property (modem_connect_en |-> // [R10]
    s.cfg[CFG_MODEM] && current_range_active == 2'b01 &&
    (s.cfg[CFG_DUAL] || s.ctrl[CTRL_RANGE_LSB + 2]))
    else $error("modem connected outside loop range");
  AST_WDOG: assert property (s_write(CFG_IDX) |=> // [R12] [R13]
    watchdog_enable == $past(pwdata[CFG_WATCHDOG_ENABLE]) &&
    watchdog_period_select == $past(pwdata[CFG_WDPD_LSB +: 2]))
    else $error("watchdog controls do not follow write");
  AST_RESET_ZERO: assert property (disable iff (1'b0) // [R14] [R15] [R18]
    rst |=> s.code == '0 && s.gain == '0 && s.zero == '0)
    else $error("data registers not zero after reset");
  AST_LOW_NIBBLE: assert property (RES_BITS == 12 |-> // [R17]
    s.code[3:0] == '0 && s.gain[3:0] == '0 && s.zero[3:0] == '0)
    else $error("low nibble held in twelve-bit mode");
  AST_ANSWER_ONE_WAIT: assert property (s_wait_answer |=> !pready)
    else $error("pready held longer than one cycle");
endmodule : dac_config_regs

// file: dac_host_model.sv
`timescale 1ns/1ps
module dac_host_model (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [dac_regs_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import dac_regs_pkg::*;
  // ---------------------------------------------------------------
  // Host side of the register bus
  // ---------------------------------------------------------------
  // Raised only by a scenario that writes reserved bits on purpose
  logic break_reserved;

  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    break_reserved = 1'b0;
  end

  // One transfer; the request is held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [15:0] wdat, output logic [31:0] rdat,
                      output logic err);
    logic [15:0] data;
    data = wdat;
    if (wr && idx == CFG_IDX && !break_reserved) begin
      data = wdat & CFG_WR_MASK;
    end
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, data};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value can never look valid
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : dac_host_model

// file: dac_config_and_code_registers_tb.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module dac_config_and_code_registers_tb;
  import dac_regs_pkg::*;
  localparam logic [7:0] RST_IDX [4] = '{CFG_IDX, CODE_IDX, GAIN_IDX,
                                         ZERO_IDX};
  logic core_clk;
  logic rst;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] calibrated_code;
  logic voltage_output_on, current_output_on, sense_ground_en;
  logic modem_connect_en, frame_check_enable, watchdog_enable;
  logic [1:0] current_range_active, watchdog_period_select;
  logic [31:0] prdata12, rdat12;
  logic [15:0] code12;
  logic pready12;
  int error_cnt = 0;
  int samples_checked = 0;

  dac_config_regs #(.RES_BITS(16)) DUT (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .calibrated_code(calibrated_code),
    .voltage_output_on(voltage_output_on),
    .current_output_on(current_output_on),
    .current_range_active(current_range_active),
    .sense_ground_en(sense_ground_en),
    .modem_connect_en(modem_connect_en),
    .frame_check_enable(frame_check_enable),
    .watchdog_enable(watchdog_enable),
    .watchdog_period_select(watchdog_period_select)
  );

  dac_host_model host (
    .core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  // Twelve-bit variant on the same bus; only its read data and calibrated code are watched
  dac_config_regs #(.RES_BITS(12)) DUT12 (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata12),
    .pready(pready12), .pslverr(), .calibrated_code(code12),
    .voltage_output_on(), .current_output_on(),
    .current_range_active(), .sense_ground_en(), .modem_connect_en(),
    .frame_check_enable(), .watchdog_enable(),
    .watchdog_period_select()
  );

  // ---------------------------------------------------------------
  // Clock and helpers
  // ---------------------------------------------------------------
  // 10 MHz core clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // Twelve-bit read data, taken at the edge where its pready stands
  always @(posedge core_clk) begin
    if (pready12) begin
      rdat12 <= prdata12;
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    host.xfer(1'b1, idx, d, rdat, err);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    host.xfer(1'b0, idx, 16'h0000, rdat, err);
  endtask : rd

  // Lets registered outputs land before they are sampled
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Some forty transfers of four cycles; 2000 cycles leaves ample slack
  initial begin
    #(100 * 2000);
    error_cnt++;
    close_out();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(RST_IDX[i]);
      `CHECK("reset value", 32'h0, rdat)
    end
    // Unmapped index is refused and reads zero
    rd(8'h20);
    `CHECK("unmapped err", 1'b1, err)
    `CHECK("unmapped data", 32'h0, rdat)
    // All ones into configuration, reserved bits must drop
    host.break_reserved = 1'b1;
    wr(CFG_IDX, 16'hffff);
    host.break_reserved = 1'b0;
    settle(1);
    `CHECK("sense ground", 1'b1, sense_ground_en)
    `CHECK("frame check", 1'b1, frame_check_enable)
    `CHECK("wd enable", 1'b1, watchdog_enable)
    `CHECK("range active", 2'h3, current_range_active)
    rd(CFG_IDX);
    `CHECK("cfg readback", {16'h0, CFG_WR_MASK}, rdat)
    for (int p = 0; p < 4; p++) begin
      wr(CFG_IDX, 16'(p));
      settle(1);
      `CHECK("wd period", 2'(p), watchdog_period_select)
      `CHECK("wd enable", 1'b0, watchdog_enable)
    end
    `CHECK("frame check", 1'b0, frame_check_enable)
    `CHECK("sense ground", 1'b0, sense_ground_en)
    // Bipolar range entry clears the code to midscale
    wr(CTRL_IDX, 16'h1000 | 16'(RANGE_BIP_10));
    settle(1);
    `CHECK("voltage on", 1'b1, voltage_output_on)
    `CHECK("current on", 1'b0, current_output_on)
    `CHECK("range active", 2'h3, current_range_active)
    rd(CODE_IDX);
    `CHECK("code clear", 32'h8000, rdat)
    // Dual output, then a secondary range change keeps the code
    wr(CODE_IDX, 16'h1234);
    wr(CFG_IDX, 16'h0500);
    settle(1);
    `CHECK("voltage on", 1'b1, voltage_output_on)
    `CHECK("current on", 1'b1, current_output_on)
    `CHECK("range active", 2'h2, current_range_active)
    `CHECK("12-bit code", 16'h1230, code12)
    wr(CFG_IDX, 16'h0300);
    rd(CODE_IDX);
    `CHECK("code kept", 32'h1234, rdat)
    settle(0);
    `CHECK("12-bit read", 32'h1230, rdat12)
    `CHECK("range active", 2'h1, current_range_active)
    // Modem path only in the 4-20 mA range
    wr(CFG_IDX, 16'h0010);
    settle(1);
    `CHECK("modem", 1'b0, modem_connect_en)
    wr(CTRL_IDX, 16'h1000 | 16'(RANGE_LOOP_4_20));
    settle(1);
    `CHECK("modem", 1'b1, modem_connect_en)
    rd(STAT_IDX);
    `CHECK("status", 32'h15, rdat)
    rd(CODE_IDX);
    `CHECK("code clear", 32'h0, rdat)
    wr(CODE_IDX, 16'h4321);
    wr(CTRL_IDX, 16'h1000 | 16'(RANGE_LOOP_4_20));
    rd(CODE_IDX);
    `CHECK("same range", 32'h4321, rdat)
    wr(CFG_IDX, 16'h0000);
    settle(1);
    `CHECK("modem", 1'b0, modem_connect_en)
    wr(CTRL_IDX, 16'h9000 | 16'(RANGE_BIP_5));
    rd(CODE_IDX);
    `CHECK("code clear", 32'h0, rdat)
    // Trim: 2000h scaled by 1.5 plus 10h once calibration is on
    wr(CODE_IDX, 16'h2000);
    wr(GAIN_IDX, 16'h8000);
    wr(ZERO_IDX, 16'h0010);
    settle(3);
    `CHECK("raw code", 16'h2000, calibrated_code)
    wr(CFG_IDX, 16'h0020);
    settle(3);
    `CHECK("trimmed code", 16'h3010, calibrated_code)
    `CHECK("12-bit trim", 16'h3010, code12)
    rd(GAIN_IDX);
    `CHECK("gain", 32'h8000, rdat)
    rd(ZERO_IDX);
    `CHECK("zero", 32'h0010, rdat)
    // A reset in mid-run returns every data register to zero
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(RST_IDX[i]);
      `CHECK("reset again", 32'h0, rdat)
    end
    `CHECK("code after reset", 16'h0, calibrated_code)
    close_out();
  end
endmodule : dac_config_and_code_registers_tb
